// file: shared/clock_select_pkg.sv
// Constants, register map and state type for the CPU clock select switch.
// Assumes a single system clock and oscillator activity delivered as
// one-cycle tick pulses synchronous to that clock.

package clock_select_pkg;

  // ==========================================================================
  // Register indices; the byte address on the bus is four times the index.
  // ==========================================================================
  localparam logic [15:0] PCC_IDX  = 16'hfffb;
  localparam logic [15:0] SUBOSCILLATION_MODE_IDX = 16'hfff0;
  localparam logic [15:0] CSS_IDX  = 16'hfff2;

  // ==========================================================================
  // Field positions.
  // ==========================================================================
  localparam int unsigned PCC_MCC_BIT  = 7;
  localparam int unsigned PCC_DIV_BIT  = 1;
  localparam int unsigned SUBOSCILLATION_MODE_FRC_BIT = 1;
  localparam int unsigned SUBOSCILLATION_MODE_SCC_BIT = 0;
  localparam int unsigned CSS_CLS_BIT  = 5;
  localparam int unsigned CSS_SEL_BIT  = 4;

  // ==========================================================================
  // Reset values.
  // ==========================================================================
  localparam logic [7:0] PCC_RESET  = 8'h02;
  localparam logic [7:0] SUBOSCILLATION_MODE_RESET = 8'h00;
  localparam logic [7:0] CSS_RESET  = 8'h00;

  // ==========================================================================
  // Dividers and timing counts, in oscillator or old CPU clock periods.
  // ==========================================================================
  localparam int unsigned MAIN_SLOW_DIV        = 4;
  localparam int unsigned SUB_CPU_DIV          = 2;
  localparam int unsigned STAB_MAIN_PERIODS    = 32768;
  localparam int unsigned STAB_CNT_W           = 16;
  localparam int unsigned SW_CNT_W             = 9;
  localparam logic [8:0]  SW_SHORT_CLKS        = 9'h002;
  localparam logic [8:0]  SW_FAST_TO_SLOW_CLKS = 9'h004;
  localparam logic [8:0]  SW_FAST_TO_SUB_CLKS  = 9'h132;
  localparam logic [8:0]  SW_SLOW_TO_SUB_CLKS  = 9'h04c;

  // ==========================================================================
  // Clock switch sequencer states.
  // ==========================================================================
  typedef enum logic [1:0] {
    ST_STABILISE,
    ST_RUN,
    ST_SWITCH
  } clk_state_t;

endpackage

// file: test/clock_select_checker.sv
// Assertions on the ports of the CPU clock select switch.
// Assumes one clock and that the bench binds it to the design top.
`timescale 1ns/10ps
module clock_select_checker
  import clock_select_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pslverr,
  input wire logic        main_osc_tick,
  input wire logic        sub_osc_tick,
  input wire logic        cpu_clk_tick,
  input wire logic        cpu_exec_en,
  input wire logic        periph_main_tick,
  input wire logic        timer_sub_tick,
  input wire logic        main_osc_stop,
  input wire logic        sub_osc_stop,
  input wire logic        feedback_resistor_off,
  input wire logic        halt_mode,
  input wire logic        stop_mode,
  input wire logic        cpu_source_status
);
  // ==========================================================
  // Helper logic
  // ==========================================================
  logic [1:0] up_cnt;
  wire        live    = up_cnt == 2'h3;
  wire        acc     = psel && penable && pwrite && pstrb[0];
  wire        css_wr  = acc && paddr == {14'h0, CSS_IDX, 2'h0};
  wire        suboscillation_mode_wr = acc && paddr == {14'h0, SUBOSCILLATION_MODE_IDX, 2'h0};
  // Skip the synchroniser edges, where outputs still hold reset values.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n)
      up_cnt <= 2'h0;
    else if (!live)
      up_cnt <= up_cnt + 2'h1;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!live);
  sequence to_sub;
    !cpu_source_status && css_wr && pwdata[4];
  endsequence
  sequence to_main;
    cpu_source_status && css_wr && !pwdata[4] && !halt_mode;
  endsequence
  // ==========================================================
  // Assertions
  // ==========================================================
  a_status_late: assert property (
    to_sub |=> !cpu_source_status [*2]) else $error("status flag rose at the write");
  a_back_to_main: assert property (
    to_main |-> ##[1:40] !cpu_source_status) else $error("switch back to main too slow");
  a_stop_main_only: assert property (
    $rose(stop_mode) |-> !$past(cpu_source_status)) else $error("stop entered on subclock");
  a_stop_kills_main: assert property (
    stop_mode |-> main_osc_stop) else $error("main oscillator runs in stop");
  a_main_stop_cause: assert property (
    main_osc_stop |-> stop_mode || cpu_source_status || $past(stop_mode) || $past(cpu_source_status))
    else $error("main oscillator stopped without cause");
  a_halt_quiet: assert property (
    halt_mode && $past(halt_mode) |-> !cpu_clk_tick) else $error("cpu tick during halt");
  a_stab_quiet: assert property (
    !cpu_exec_en && !$past(cpu_exec_en) |-> !cpu_clk_tick) else $error("cpu tick while held");
  a_sub_tick_src: assert property (
    timer_sub_tick |-> $past(sub_osc_tick)) else $error("timer tick without sub tick");
  a_main_tick_src: assert property (
    periph_main_tick |-> $past(main_osc_tick)) else $error("peripheral tick without main tick");
  a_suboscillation_mode_write: assert property (
    suboscillation_mode_wr |=> sub_osc_stop == $past(pwdata[0]) && feedback_resistor_off == $past(pwdata[1]))
    else $error("suboscillation bits not applied");
endmodule

// file: test/tb_top.sv
// Self-checking bench for the CPU clock select switch over APB.
// Assumes zero wait states; main ticks every cycle, sub ticks every fourth.
`timescale 1ns/10ps
module tb_top;
  import clock_select_pkg::*;
  localparam logic [31:0] PCC_A  = {14'h0, PCC_IDX, 2'h0};
  localparam logic [31:0] SUBOSCILLATION_MODE_A = {14'h0, SUBOSCILLATION_MODE_IDX, 2'h0};
  localparam logic [31:0] CSS_A  = {14'h0, CSS_IDX, 2'h0};
  logic        clk_sys, reset_n, psel, penable, pwrite, pready, pslverr, err;
  logic        main_osc_tick, sub_osc_tick, halt_req, stop_req, wake_req;
  logic        cpu_clk_tick, cpu_exec_en, periph_main_tick, timer_sub_tick;
  logic        main_osc_stop, sub_osc_stop, feedback_resistor_off, halt_mode, stop_mode, cpu_source_status;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [3:0]  pstrb;
  int          fail_count, tests_run, cyc, n;
  cpu_clock_select_switch #(.STAB_TICKS(16)) dut (.*);
  // ==========================================================
  // Clock, sub ticks and hang guard
  // ==========================================================
  always #10 clk_sys = ~clk_sys;
  // A hang counts as a mismatch so the verdict cannot pass.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    sub_osc_tick <= cyc[1:0] == 2'h3;
    if (cyc > 6000) begin
      fail_count++;
      end_sim();
    end
  end
  // ==========================================================
  // Tasks
  // ==========================================================
  task automatic end_sim;
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  // One APB transfer; the leading edge keeps release and setup apart.
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic ticks(input int cycles, input int exp);
    n = 0;
    repeat (cycles) begin
      @(negedge clk_sys);
      if (cpu_clk_tick === 1'b1) n++;
    end
    chk(n, exp);
  endtask
  // Pulses stop_req (0), halt_req (1) or wake_req (2) for one cycle.
  task automatic pulse(input int which);
    @(posedge clk_sys);
    stop_req <= which == 0;
    halt_req <= which == 1;
    wake_req <= which == 2;
    @(posedge clk_sys);
    {stop_req, halt_req, wake_req} <= 3'h0;
    @(negedge clk_sys);
  endtask
  task automatic wait_flag(input logic want, input int lim);
    n = 0;
    // Waits for execution enable (want high) or for the status flag to show the subclock.
    while ((want ? cpu_exec_en : cpu_source_status) !== 1'b1 && n < lim) begin
      @(negedge clk_sys);
      n++;
    end
  endtask
  // ==========================================================
  // Test sequence
  // ==========================================================
  initial begin
    {clk_sys, reset_n, psel, penable, pwrite, halt_req, stop_req, wake_req} = 8'h0;
    {paddr, pwdata, fail_count, tests_run} = 0;
    pstrb = 4'h1;
    main_osc_tick = 1'b1;
    repeat (20) @(posedge clk_sys);
    chkb(main_osc_stop, 1'b1);
    reset_n <= 1'b1;
    wait_flag(1'b1, 100);
    chkb(n >= 16 && n <= 24, 1'b1);
    rdchk(PCC_A, 32'h02);
    rdchk(SUBOSCILLATION_MODE_A, 32'h00);
    $display("test reset done");
    ticks(40, 10);
    apb(1'b1, CSS_A, 32'h20);
    rdchk(CSS_A, 32'h00);
    apb(1'b1, PCC_A, 32'h00);
    repeat (20) @(negedge clk_sys);
    ticks(40, 40);
    chkb(cpu_source_status, 1'b0);
    apb(1'b0, 32'h100, 32'h0);
    chk({rd[31:1], err}, 32'h1);
    $display("test main modes done");
    apb(1'b1, CSS_A, 32'h10);
    rdchk(CSS_A, 32'h10);
    wait_flag(1'b0, 400);
    chkb(n >= 290 && n <= 310, 1'b1);
    rdchk(CSS_A, 32'h30);
    apb(1'b1, PCC_A, 32'h02);
    ticks(80, 10);
    $display("test to subclock done");
    pulse(0);
    chkb(stop_mode, 1'b0);
    pulse(1);
    chkb(halt_mode, 1'b1);
    ticks(16, 0);
    pulse(2);
    chkb(halt_mode, 1'b0);
    apb(1'b1, PCC_A, 32'h80);
    repeat (2) @(negedge clk_sys);
    chkb(main_osc_stop, 1'b1);
    apb(1'b1, PCC_A, 32'h00);
    repeat (40) @(negedge clk_sys);
    chkb(main_osc_stop, 1'b0);
    apb(1'b1, CSS_A, 32'h00);
    wait_flag(1'b1, 0);
    n = 0;
    while (cpu_source_status !== 1'b0 && n < 60) begin
      @(negedge clk_sys);
      n++;
    end
    chkb(n <= 30, 1'b1);
    $display("test standby and return done");
    apb(1'b1, SUBOSCILLATION_MODE_A, 32'h03);
    rdchk(SUBOSCILLATION_MODE_A, 32'h03);
    chk({sub_osc_stop, feedback_resistor_off}, 32'h3);
    apb(1'b1, SUBOSCILLATION_MODE_A, 32'h00);
    pulse(0);
    chk({stop_mode, main_osc_stop}, 32'h3);
    pulse(2);
    wait_flag(1'b1, 100);
    chkb(cpu_exec_en, 1'b1);
    $display("test oscillator control done");
    end_sim();
  end
endmodule
bind cpu_clock_select_switch clock_select_checker chk_i (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pslverr(pslverr),
  .main_osc_tick(main_osc_tick), .sub_osc_tick(sub_osc_tick), .cpu_clk_tick(cpu_clk_tick),
  .cpu_exec_en(cpu_exec_en), .periph_main_tick(periph_main_tick), .timer_sub_tick(timer_sub_tick),
  .main_osc_stop(main_osc_stop), .sub_osc_stop(sub_osc_stop), .feedback_resistor_off(feedback_resistor_off),
  .halt_mode(halt_mode), .stop_mode(stop_mode), .cpu_source_status(cpu_source_status));

// file: verilog/cpu_clock_select_switch.sv
// CPU clock select switch with its three control registers on APB.
// Assumes oscillator activity arrives as synchronous tick pulses and that the
// CPU core consumes cpu_clk_tick as its clock enable.

`timescale 1ns/10ps

module cpu_clock_select_switch
  import clock_select_pkg::*;
#(
  parameter int unsigned STAB_TICKS = STAB_MAIN_PERIODS
) (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        main_osc_tick,
  input  wire logic        sub_osc_tick,
  input  wire logic        halt_req,
  input  wire logic        stop_req,
  input  wire logic        wake_req,
  output logic             cpu_clk_tick,
  output logic             cpu_exec_en,
  output logic             periph_main_tick,
  output logic             timer_sub_tick,
  output logic             main_osc_stop,
  output logic             sub_osc_stop,
  output logic             feedback_resistor_off,
  output logic             halt_mode,
  output logic             stop_mode,
  output logic             cpu_source_status
);

  // ==========================================================================
  // Reset release
  // ==========================================================================
  logic rst_meta_reg;
  logic rst_n_sync;

  // The external reset asserts at once and releases two edges later.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_n_sync   <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_sync   <= rst_meta_reg;
    end
  end

  // ==========================================================================
  // Register state
  // ==========================================================================
  logic       main_osc_disable_reg;
  logic       main_divider_select_reg;
  logic       feedback_resistor_off_reg;
  logic       sub_osc_disable_reg;
  logic       osc_source_select_reg;
  logic       act_sub_reg;
  logic       act_div_reg;
  logic       act_sub_next;
  logic       act_div_next;
  clk_state_t state_reg;
  clk_state_t state_next;
  logic       halt_reg;
  logic       halt_next;
  logic       stop_reg;
  logic       stop_next;
  logic       main_stop_reg;
  logic       main_stop_next;
  logic       cpu_tick_reg;
  logic       cpu_tick_next;
  logic       periph_tick_reg;
  logic       timer_tick_reg;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;

  // ==========================================================================
  // APB decode
  // ==========================================================================
  logic        apb_setup;
  logic        apb_access;
  logic        hit_pcc;
  logic        hit_suboscillation_mode;
  logic        hit_css;
  logic        mapped;
  logic        wr_ok;
  logic        wr_pcc;
  logic        wr_suboscillation_mode;
  logic        wr_css;
  logic [7:0]  pcc_view;
  logic [7:0]  suboscillation_mode_view;
  logic [7:0]  css_view;

  // Registers sit at four times their index; only byte lane 0 carries data.
  assign apb_setup  = psel && !penable;
  assign apb_access = psel && penable;
  assign hit_pcc    = (paddr == {14'h0000, PCC_IDX, 2'b00});
  assign hit_suboscillation_mode   = (paddr == {14'h0000, SUBOSCILLATION_MODE_IDX, 2'b00});
  assign hit_css    = (paddr == {14'h0000, CSS_IDX, 2'b00});
  assign mapped     = hit_pcc || hit_suboscillation_mode || hit_css;
  assign wr_ok      = apb_access && pwrite && pstrb[0];
  assign wr_pcc     = wr_ok && hit_pcc;
  assign wr_suboscillation_mode    = wr_ok && hit_suboscillation_mode;
  assign wr_css     = wr_ok && hit_css;

  // Zero wait states; read data is captured in the setup cycle.
  assign pready  = 1'b1;
  assign pslverr = apb_access && !mapped;
  assign prdata  = prdata_reg;

  // Read views: unused bits always read as zero.
  assign pcc_view  = {main_osc_disable_reg, 5'h00, main_divider_select_reg, 1'b0};
  assign suboscillation_mode_view = {6'h00, feedback_resistor_off_reg, sub_osc_disable_reg};
  assign css_view  = {2'h0, act_sub_reg, osc_source_select_reg, 4'h0};

  // Address decode for the read mux, an unmapped address returns zero.
  assign prdata_next = !apb_setup ? prdata_reg :
                       hit_pcc    ? {24'h000000, pcc_view} :
                       hit_suboscillation_mode   ? {24'h000000, suboscillation_mode_view} :
                       hit_css    ? {24'h000000, css_view} : 32'h00000000;

  always_ff @(posedge clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      prdata_reg <= 32'h00000000;
    end else begin
      prdata_reg <= prdata_next;
    end
  end

  // ==========================================================================
  // Control registers
  // ==========================================================================
  // processor clock reset value
  always_ff @(posedge clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      main_osc_disable_reg      <= PCC_RESET[PCC_MCC_BIT];
      main_divider_select_reg   <= PCC_RESET[PCC_DIV_BIT];
      feedback_resistor_off_reg <= SUBOSCILLATION_MODE_RESET[SUBOSCILLATION_MODE_FRC_BIT];
      sub_osc_disable_reg       <= SUBOSCILLATION_MODE_RESET[SUBOSCILLATION_MODE_SCC_BIT];
      osc_source_select_reg     <= CSS_RESET[CSS_SEL_BIT];
    end else begin
      if (wr_pcc) begin
        main_osc_disable_reg    <= pwdata[PCC_MCC_BIT];
        main_divider_select_reg <= pwdata[PCC_DIV_BIT];
      end
      if (wr_suboscillation_mode) begin
        feedback_resistor_off_reg <= pwdata[SUBOSCILLATION_MODE_FRC_BIT];
        sub_osc_disable_reg       <= pwdata[SUBOSCILLATION_MODE_SCC_BIT];
      end
      if (wr_css) begin
        osc_source_select_reg <= pwdata[CSS_SEL_BIT];
      end
    end
  end

  // ==========================================================================
  // Oscillator gating and clock sources
  // ==========================================================================
  logic main_tick_ok;
  logic sub_tick_ok;
  logic main_slow_tick;
  logic sub_half_tick;
  logic old_cpu_tick;

  // A stopped oscillator's ticks are ignored even if the pad still toggles.
  // subsystem oscillator stop
  assign main_tick_ok = main_osc_tick && !main_stop_reg;
  assign sub_tick_ok  = sub_osc_tick && !sub_osc_disable_reg;

  tick_divider #(
    .DIV      (MAIN_SLOW_DIV)
  ) u_main_slow_div (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n_sync),
    .tick_in  (main_tick_ok),
    .tick_out (main_slow_tick)
  );

  tick_divider #(
    .DIV      (SUB_CPU_DIV)
  ) u_sub_half_div (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n_sync),
    .tick_in  (sub_tick_ok),
    .tick_out (sub_half_tick)
  );

  assign old_cpu_tick = act_sub_reg ? sub_half_tick :
                        act_div_reg ? main_slow_tick : main_tick_ok;

  // ==========================================================================
  // Stabilisation and switch delay counters
  // ==========================================================================
  logic                stab_load;
  logic                stab_zero;
  logic                sw_load;
  logic [SW_CNT_W-1:0] sw_load_val;
  logic                sw_zero;
  logic                req_sub;
  logic                req_div;
  logic                req_differs;

  // both select bits form the request
  assign req_sub     = osc_source_select_reg;
  assign req_div     = main_divider_select_reg;
  assign req_differs = (req_sub != act_sub_reg) || (!req_sub && (req_div != act_div_reg));

  assign sw_load_val = act_sub_reg            ? SW_SHORT_CLKS :
                       (req_sub && act_div_reg) ? SW_SLOW_TO_SUB_CLKS :
                       req_sub                  ? SW_FAST_TO_SUB_CLKS :
                       act_div_reg              ? SW_SHORT_CLKS : SW_FAST_TO_SLOW_CLKS;

  tick_counter #(
    .W         (STAB_CNT_W),
    .RESET_VAL (STAB_TICKS)
  ) u_stab_cnt (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n_sync),
    .load      (stab_load),
    .load_val  (STAB_CNT_W'(STAB_TICKS)),
    .tick      (main_tick_ok),
    .is_zero   (stab_zero)
  );

  tick_counter #(
    .W         (SW_CNT_W),
    .RESET_VAL (0)
  ) u_switch_cnt (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n_sync),
    .load      (sw_load),
    .load_val  (sw_load_val),
    .tick      (old_cpu_tick),
    .is_zero   (sw_zero)
  );

  // ==========================================================================
  // Switch sequencer
  // ==========================================================================
  // The active source only changes when the old-clock delay has run out, so the
  // status flag and the CPU see the same moment of change.
  always_comb begin
    state_next   = state_reg;
    act_sub_next = act_sub_reg;
    act_div_next = act_div_reg;
    sw_load      = 1'b0;
    stab_load    = 1'b0;
    case (state_reg)
      ST_STABILISE: begin
        if (stab_zero) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (stop_reg && wake_req) begin
          // Leaving STOP restarts the main oscillator, so wait for it again.
          stab_load  = 1'b1;
          state_next = ST_STABILISE;
        end else if (req_differs && !stop_reg) begin
          sw_load    = 1'b1;
          state_next = ST_SWITCH;
        end
      end
      ST_SWITCH: begin
        if (sw_zero) begin
          act_sub_next = req_sub;
          act_div_next = req_div;
          state_next   = ST_RUN;
        end
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      state_reg   <= ST_STABILISE;
      act_sub_reg <= CSS_RESET[CSS_SEL_BIT];
      act_div_reg <= PCC_RESET[PCC_DIV_BIT];
    end else begin
      state_reg   <= state_next;
      act_sub_reg <= act_sub_next;
      act_div_reg <= act_div_next;
    end
  end

  // ==========================================================================
  // Standby modes
  // ==========================================================================
  // A request arriving together with a wake-up still enters standby.
  // STOP refused on subsystem clock
  assign halt_next = halt_req || (halt_reg && !wake_req);
  assign stop_next = (stop_req && !act_sub_reg && state_reg == ST_RUN) || (stop_reg && !wake_req);

  always_ff @(posedge clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      halt_reg <= 1'b0;
      stop_reg <= 1'b0;
    end else begin
      halt_reg <= halt_next;
      stop_reg <= stop_next;
    end
  end

  // ==========================================================================
  // Main oscillator control
  // ==========================================================================
  // The disable bit only bites while the subsystem clock really drives the CPU,
  // so a premature write cannot starve the CPU of its running clock.
  // main stop on subsystem clock
  // main oscillator held stopped in reset
  assign main_stop_next = stop_next || (main_osc_disable_reg && act_sub_reg && state_reg == ST_RUN);

  always_ff @(posedge clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      main_stop_reg <= 1'b1;
    end else begin
      main_stop_reg <= main_stop_next;
    end
  end

  // ==========================================================================
  // Clock outputs
  // ==========================================================================
  // CPU ticks are withheld during stabilisation and standby; during a switch
  // the old clock keeps running.
  assign cpu_tick_next = old_cpu_tick && state_reg != ST_STABILISE && !halt_reg && !stop_reg;

  always_ff @(posedge clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      cpu_tick_reg    <= 1'b0;
      periph_tick_reg <= 1'b0;
      timer_tick_reg  <= 1'b0;
    end else begin
      cpu_tick_reg    <= cpu_tick_next;
      periph_tick_reg <= main_tick_ok;
      timer_tick_reg  <= sub_tick_ok;
    end
  end

  assign cpu_clk_tick          = cpu_tick_reg;
  assign cpu_exec_en           = (state_reg != ST_STABILISE) && !halt_reg && !stop_reg;
  assign periph_main_tick      = periph_tick_reg;
  assign timer_sub_tick        = timer_tick_reg;
  assign main_osc_stop         = main_stop_reg;
  assign sub_osc_stop          = sub_osc_disable_reg;
  assign feedback_resistor_off = feedback_resistor_off_reg;
  assign halt_mode             = halt_reg;
  assign stop_mode             = stop_reg;
  assign cpu_source_status     = act_sub_reg;

endmodule

// file: verilog/tick_counter.sv
// Loadable down counter that steps on tick pulses and flags zero.
// Assumes load and tick are synchronous; load takes priority over tick.

`timescale 1ns/10ps

module tick_counter #(
  parameter int unsigned W         = 9,
  parameter int unsigned RESET_VAL = 0
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         tick,
  output logic              is_zero
);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;

  // ==========================================================================
  // Counter
  // ==========================================================================
  // Stops at zero so a late tick cannot wrap it around.
  assign cnt_next = load ? load_val : (tick && cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg;
  assign is_zero  = (cnt_reg == '0);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= W'(RESET_VAL);
    end else begin
      cnt_reg <= cnt_next;
    end
  end

endmodule

// file: verilog/tick_divider.sv
// Divides a stream of one-cycle tick pulses by a fixed ratio.
// Assumes input ticks are synchronous one-cycle pulses on clk_sys.

`timescale 1ns/10ps

module tick_divider #(
  parameter int unsigned DIV = 4
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic tick_in,
  output logic      tick_out
);

  localparam int unsigned CW = (DIV > 2) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic          out_reg;
  logic          out_next;

  // ==========================================================================
  // Divider
  // ==========================================================================
  // One output tick every DIV input ticks, registered to stay glitch free.
  assign cnt_next = !tick_in ? cnt_reg : (cnt_reg == LAST) ? '0 : cnt_reg + 1'b1;
  assign out_next = tick_in && (cnt_reg == LAST);
  assign tick_out = out_reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      out_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      out_reg <= out_next;
    end
  end

endmodule
